// [rtl/fsw_status_latch.v]
`timescale 1ns/1ns
`include "fsw_consts.vh"
module fsw_status_latch (
  input  wire       core_clk_in,
  input  wire       rst_n_in,
  input  wire       spi_clk_in,
  input  wire       spi_cs_n_in,
  input  wire       spi_mosi_in,
  input  wire       wp_n_in,
  output reg        spi_miso_out,
  output reg        spi_miso_oe_n_out,
  output reg  [7:0] status_out,
  output reg        quad_lane_enable_out,
  output reg        op_start_out,
  output reg  [7:0] op_code_out
);
  wire [3:0] sync_w;
  wire       sclk_s;
  wire       cs_n_s;
  wire       mosi_s;
  wire       wp_n_s;

  // the SPI and write protect pins cross two flops before use; reset acts directly
  fsw_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({spi_clk_in, spi_cs_n_in, spi_mosi_in, wp_n_in}),
    .q_out    (sync_w)
  );
  assign sclk_s = sync_w[3];
  assign cs_n_s = sync_w[2];
  assign mosi_s = sync_w[1];
  assign wp_n_s = sync_w[0];

  reg        sclk_prev_q;
  reg        cs_prev_q;
  reg  [2:0] bit_cnt_q;
  reg  [3:0] byte_cnt_q;
  reg  [7:0] rx_sh_q;
  reg  [7:0] opcode_q;
  reg  [31:0] addr_q;
  reg  [7:0] tx_sh_q;
  reg        have_op_q;
  reg  [5:0] nv_q;          // {write disable, quad, protect 3..0}
  reg        latch_q;
  reg        busy_q;
  reg        susp_q;
  reg        pe_op_q;
  reg        rst_armed_q;
  reg  [15:0] op_cnt_q;

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire cs_rise   = cs_n_s & ~cs_prev_q;
  wire selected  = ~cs_n_s;
  wire [7:0] rx_byte = {rx_sh_q[6:0], mosi_s};

  // opcodes that need the write enable latch
  function is_gated;
    input [7:0] op;
    begin
      case (op)
        8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21,
        8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65,
        8'h85, 8'h83, 8'h64, 8'h62, 8'h15, 8'h18, 8'hfb,
        8'he1, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91, 8'h7e, 8'h98,
        8'he8, 8'h43, 8'h4a: is_gated = 1'b1;
        default:             is_gated = 1'b0;
      endcase
    end
  endfunction

  // program and erase opcodes that carry an array address
  function [3:0] addr_bytes;
    input [7:0] op;
    begin
      case (op)
        8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8: addr_bytes = `FSW_ADDR3;
        8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc:        addr_bytes = `FSW_ADDR4;
        default:                                        addr_bytes = 4'h0;
      endcase
    end
  endfunction

  // lowest protected 64KB block for a pattern, top area
  function [9:0] prot_floor;
    input [3:0] bp;
    begin
      case (bp)
        4'h0:    prot_floor = `FSW_BLOCKS;
        4'h1:    prot_floor = 10'h1ff;
        4'h2:    prot_floor = 10'h1fe;
        4'h3:    prot_floor = 10'h1fc;
        4'h4:    prot_floor = 10'h1f8;
        4'h5:    prot_floor = 10'h1f0;
        4'h6:    prot_floor = 10'h1e0;
        4'h7:    prot_floor = 10'h1c0;
        4'h8:    prot_floor = 10'h180;
        4'h9:    prot_floor = 10'h100;
        4'ha:    prot_floor = 10'h080;
        4'hb:    prot_floor = 10'h040;
        4'hc:    prot_floor = 10'h020;
        4'hd:    prot_floor = 10'h010;
        4'he:    prot_floor = 10'h008;
        default: prot_floor = 10'h000;
      endcase
    end
  endfunction

  // decisions taken when the frame closes
  wire [3:0] bp       = nv_q[`FSW_BP_MSB-`FSW_BP_LSB:0];
  wire       quad_en  = nv_q[`FSW_BIT_QUAD-`FSW_BP_LSB];
  wire       wr_dis   = nv_q[`FSW_BIT_WR_DIS-`FSW_BP_LSB];
  wire [3:0] naddr    = addr_bytes(opcode_q);
  wire       is_addr  = (naddr != 4'h0);
  wire       is_chip  = (opcode_q == `FSW_OP_CHIP_ERASE_A) | (opcode_q == `FSW_OP_CHIP_ERASE_B);
  wire [9:0] blk      = (naddr == `FSW_ADDR4) ? {1'b0, addr_q[24:16]} : {2'b00, addr_q[23:16]};
  wire       frame_ok = cs_rise & have_op_q & (bit_cnt_q == 3'h0);
  // pin is a data lane under quad enable
  wire       wp_low   = ~quad_en & ~wp_n_s;
  wire       prot_hit = (is_addr & (blk >= prot_floor(bp))) | (is_chip & (bp != 4'h0));
  // hardware protection of the status register
  wire       sr_lock  = (opcode_q == `FSW_OP_STATUS_WR) & wr_dis & wp_low;
  wire       enough   = is_addr ? (byte_cnt_q > naddr) :
                        (opcode_q == `FSW_OP_STATUS_WR) ? (byte_cnt_q >= `FSW_BYTE_TWO) : 1'b1;
  wire       start_op = frame_ok & ~busy_q & is_gated(opcode_q) & latch_q & enough & ~prot_hit & ~sr_lock;
  wire       do_reset = frame_ok & (opcode_q == `FSW_OP_RST) & rst_armed_q;
  // suspend only breaks a program or erase
  wire       do_susp  = frame_ok & busy_q & pe_op_q & (opcode_q == `FSW_OP_SUSP);
  wire       do_res   = frame_ok & ~busy_q & susp_q & (opcode_q == `FSW_OP_RESUME);
  wire       op_done  = busy_q & (op_cnt_q == 16'h0000);
  // bit placement of the status byte
  wire [7:0] status_w = {nv_q, latch_q, busy_q};

  // edge history of the synchronised pins
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_prev_q <= 1'b1;              // matches the synchroniser reset, no false edge
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  // input framing: bytes counted on rising clock edges
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 4'h0;
      rx_sh_q    <= 8'h00;
      opcode_q   <= 8'h00;
      addr_q     <= 32'h0000_0000;
      have_op_q  <= 1'b0;
    end else if (!selected) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 4'h0;
      have_op_q  <= 1'b0;
    end else if (sclk_rise) begin
      rx_sh_q   <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == `FSW_BITS_MAX) begin
        if (byte_cnt_q != `FSW_BYTE_MAX)
          byte_cnt_q <= byte_cnt_q + 4'h1;
        if (byte_cnt_q == 4'h0) begin
          opcode_q  <= rx_byte;
          have_op_q <= 1'b1;
          addr_q    <= 32'h0000_0000;
        end else if (byte_cnt_q <= addr_bytes(opcode_q) || byte_cnt_q == `FSW_BYTE_ONE) begin
          // address bytes, or the data byte of a status write
          addr_q <= {addr_q[23:0], rx_byte};
        end
      end
    end
  end

  // status read repeats until deselect, busy or not
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_q           <= 8'h00;
      spi_miso_out      <= 1'b0;
      spi_miso_oe_n_out <= 1'b1;
    end else if (!selected) begin
      spi_miso_oe_n_out <= 1'b1;
    end else if (sclk_fall && have_op_q &&
                 (opcode_q == `FSW_OP_RDSR || opcode_q == `FSW_OP_RDERP)) begin
      spi_miso_oe_n_out <= 1'b0;
      if (bit_cnt_q == 3'h0) begin
        // reload each byte so the live busy flag is seen
        tx_sh_q      <= (opcode_q == `FSW_OP_RDSR) ? {status_w[6:0], 1'b0} : 8'h00;
        spi_miso_out <= (opcode_q == `FSW_OP_RDSR) ? status_w[`FSW_BIT_WR_DIS] : 1'b0;
      end else begin
        tx_sh_q      <= {tx_sh_q[6:0], 1'b0};
        spi_miso_out <= tx_sh_q[7];
      end
    end
  end

  // nonvolatile bits, written only by status write
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nv_q <= `FSW_NV_RESET;
    end else if (start_op && opcode_q == `FSW_OP_STATUS_WR) begin
      nv_q <= addr_q[7:2];
    end
  end

  // write enable latch
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= 1'b0;
    end else if (do_reset || (op_done && !susp_q)) begin
      // latch drops when the write completes
      latch_q <= 1'b0;
    end else if (frame_ok && !busy_q && opcode_q == `FSW_OP_LATCH_SET) begin
      latch_q <= 1'b1;
    end else if (frame_ok && !busy_q && opcode_q == `FSW_OP_LATCH_CLR) begin
      latch_q <= 1'b0;
    end
  end

  // busy timer; while busy only status reads, suspend and reset are acted on
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q      <= 1'b0;
      susp_q      <= 1'b0;
      pe_op_q     <= 1'b0;
      rst_armed_q <= 1'b0;
      op_cnt_q    <= 16'h0000;
    end else begin
      if (frame_ok)
        rst_armed_q <= (opcode_q == `FSW_OP_RSTEN);
      if (do_reset) begin
        busy_q  <= 1'b0;
        susp_q  <= 1'b0;
        pe_op_q <= 1'b0;
      end else if (start_op) begin
        busy_q   <= 1'b1;
        pe_op_q  <= is_addr | is_chip;
        op_cnt_q <= `FSW_OP_CYCLES;
      end else if (do_susp) begin
        // counter is held so resume finishes the remainder
        busy_q <= 1'b0;
        susp_q <= 1'b1;
      end else if (do_res) begin
        busy_q <= 1'b1;
        susp_q <= 1'b0;
      end else if (op_done) begin
        busy_q  <= 1'b0;
        pe_op_q <= 1'b0;
      end else if (busy_q) begin
        op_cnt_q <= op_cnt_q - 16'h0001;
      end
    end
  end

  // registered outputs toward the array and the pads
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out           <= `FSW_STATUS_RESET;
      quad_lane_enable_out <= 1'b0;
      op_start_out         <= 1'b0;
      op_code_out          <= 8'h00;
    end else begin
      status_out           <= status_w;
      // pattern and lane mode drive the array and pads
      quad_lane_enable_out <= quad_en;
      op_start_out         <= start_op;
      if (start_op)
        op_code_out <= opcode_q;
    end
  end
endmodule

// [pkg/fsw_consts.vh]
`ifndef FSW_CONSTS_VH
`define FSW_CONSTS_VH

// status register layout
`define FSW_BIT_BUSY      0
`define FSW_BIT_LATCH     1
`define FSW_BP_LSB        2
`define FSW_BP_MSB        5
`define FSW_BIT_QUAD      6
`define FSW_BIT_WR_DIS    7
`define FSW_STATUS_RESET  8'h00
`define FSW_NV_RESET      6'h00

// opcodes
`define FSW_OP_LATCH_SET  8'h06
`define FSW_OP_LATCH_CLR  8'h04
`define FSW_OP_RDSR       8'h05
`define FSW_OP_RDERP      8'h81
`define FSW_OP_STATUS_WR  8'h01
`define FSW_OP_RSTEN      8'h66
`define FSW_OP_RST        8'h99
`define FSW_OP_SUSP       8'h75
`define FSW_OP_RESUME     8'h7a
`define FSW_OP_CHIP_ERASE_A 8'hc7
`define FSW_OP_CHIP_ERASE_B 8'h60

// framing and timing
`define FSW_BITS_MAX      3'h7
`define FSW_BYTE_ONE      4'h1
`define FSW_BYTE_TWO      4'h2
`define FSW_BYTE_MAX      4'hf
`define FSW_ADDR3         4'h3
`define FSW_ADDR4         4'h4
`define FSW_OP_CYCLES     16'h0100
`define FSW_BLOCKS        10'h200
`endif

// [rtl/fsw_sync.v]
`timescale 1ns/1ns
`include "fsw_consts.vh"
module fsw_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // two stages; only the second is visible outside
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule

// [bench/fsw_chk.sv]
`timescale 1ns/1ns
`include "fsw_consts.vh"
module fsw_chk (
  input wire       core_clk_in,
  input wire       rst_n_in,
  input wire       spi_cs_n_in,
  input wire       spi_miso_oe_n_out,
  input wire [7:0] status_out,
  input wire       quad_lane_enable_out,
  input wire       op_start_out,
  input wire [7:0] op_code_out
);
  logic [8:0] busy_q;

  // length of the current busy spell; a stuck counter would hide a hung operation
  always @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) busy_q <= 9'h000;
    else busy_q <= status_out[0] ? busy_q + 9'h001 : 9'h000;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  busy_set_a: assert property (op_start_out |-> ##[0:2] status_out[0])
    else $error("busy missing after start");
  busy_len_a: assert property ($fell(status_out[0]) |-> busy_q == 9'h101)
    else $error("busy spell length wrong");
  wel_drop_a: assert property ($fell(status_out[0]) |-> !status_out[1])
    else $error("latch kept after operation");
  no_start_busy_a: assert property (busy_q > 9'h002 |-> !op_start_out)
    else $error("operation accepted while busy");
  start_wel_a: assert property (op_start_out |-> status_out[1])
    else $error("operation accepted without latch");
  quad_mirror_a: assert property (quad_lane_enable_out == status_out[6])
    else $error("quad output differs from status");
  oe_release_a: assert property ($rose(spi_cs_n_in) |-> ##[1:8] spi_miso_oe_n_out)
    else $error("output kept driven after deselect");
  nv_write_a: assert property (!$stable(status_out[7:2]) |->
    op_start_out || $past(op_start_out) || $past(op_start_out, 2))
    else $error("protect bits changed without write");
  erase_bp_a: assert property (op_start_out ##1 (op_code_out == `FSW_OP_CHIP_ERASE_A ||
    op_code_out == `FSW_OP_CHIP_ERASE_B) |-> status_out[5:2] == 4'h0)
    else $error("chip erase ran with protection set");

  cover property (op_start_out);
  cover property ($fell(status_out[0]));
  cover property (status_out[7] && status_out[1]);
endmodule

bind fsw_status_latch fsw_chk u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_n_out(spi_miso_oe_n_out), .status_out(status_out),
  .quad_lane_enable_out(quad_lane_enable_out), .op_start_out(op_start_out), .op_code_out(op_code_out));

// [bench/fsw_host_model.sv]
`timescale 1ns/1ns
module fsw_host_model (
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input  wire  spi_miso_in
);
  // mode 0: clock rests low between frames
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // one frame, bytes taken from the top of tx, 125 ns link period
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    spi_cs_n_out = 1'b0;
    #63;
    for (int i = 0; i < n * 8; i++) begin
      spi_mosi_out = tx[63-i];
      #62 spi_clk_out = 1'b1;
      rx = {rx[62:0], spi_miso_in};
      #63 spi_clk_out = 1'b0;
    end
    spi_mosi_out = ~spi_mosi_out; // no stale level between frames
    #63 spi_cs_n_out = 1'b1;
    #200;
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
`include "fsw_consts.vh"
module tb_top;
  logic        core_clk_in;
  logic        rst_n_in;
  logic        wp_n_in;
  wire         sclk;
  wire         cs_n;
  wire         mosi;
  wire         miso;
  wire         quad;
  wire         start;
  wire  [7:0]  status;
  wire  [7:0]  code;
  logic        start_q;
  logic [63:0] rx;
  logic [7:0]  d;
  logic [7:0]  exp_q[$];
  int          fails;
  int          check_count;

  fsw_status_latch u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .spi_clk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .wp_n_in(wp_n_in), .spi_miso_out(miso),
    .spi_miso_oe_n_out(), .status_out(status), .quad_lane_enable_out(quad),
    .op_start_out(start), .op_code_out(code));
  fsw_host_model u_host (.spi_clk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
    .spi_miso_in(miso));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic send(input logic [63:0] tx, input int n);
    u_host.xfer(tx, n, rx);
  endtask

  // three status bytes in one frame must all match
  task automatic rd_status(input logic [7:0] want);
    send({`FSW_OP_RDSR, 56'h0}, 4);
    check(rx[23:16], want);
    check(rx[15:8], want);
    check(rx[7:0], want);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 400 && status[0] !== 1'b0; i++)
      @(posedge core_clk_in);
    if (status[0] !== 1'b0) fails++;
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // code is compared a cycle after the pulse, once the held value has settled
  always @(posedge core_clk_in) begin
    start_q <= start;
    if (start_q === 1'b1) begin
      if (exp_q.size() == 0) check(code, 8'h00);
      else check(code, exp_q.pop_front());
    end
  end

  initial begin
    #600000;
    fails++;
    give_verdict;
  end

  initial begin
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    fails = 0;
    check_count = 0;
    d = 8'($urandom(42));
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    rd_status(8'h00);
    send({8'h20, 24'h010000, 32'h0}, 4);
    rd_status(8'h00);
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    rd_status(8'h02);
    send({`FSW_OP_LATCH_CLR, 56'h0}, 1);
    rd_status(8'h00);
    // random quad and protect bits 3..1, protect bit 0 set; the two bits below it set to show they are ignored
    d = d & 8'h7f | 8'h07;
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(`FSW_OP_STATUS_WR);
    send({`FSW_OP_STATUS_WR, d, 48'h0}, 2);
    wait_idle;
    rd_status({d[7:2], 2'b00});
    check({7'h00, quad}, {7'h00, d[6]});
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    send({`FSW_OP_CHIP_ERASE_A, 56'h0}, 1);
    rd_status({d[7:2], 2'b10});
    exp_q.push_back(`FSW_OP_STATUS_WR);
    send({`FSW_OP_STATUS_WR, 8'h80, 48'h0}, 2);
    wait_idle;
    @(posedge core_clk_in);
    wp_n_in <= 1'b0;
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    send({`FSW_OP_STATUS_WR, 8'h3c, 48'h0}, 2);
    rd_status(8'h82);
    @(posedge core_clk_in);
    wp_n_in <= 1'b1;
    exp_q.push_back(`FSW_OP_STATUS_WR);
    send({`FSW_OP_STATUS_WR, 8'h00, 48'h0}, 2);
    send({`FSW_OP_CHIP_ERASE_B, 56'h0}, 1);
    wait_idle;
    rd_status(8'h00);
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(`FSW_OP_CHIP_ERASE_B);
    send({`FSW_OP_CHIP_ERASE_B, 56'h0}, 1);
    send({`FSW_OP_RDSR, 56'h0}, 2);
    check(rx[7:0], 8'h03);
    wait_idle;
    rd_status(8'h00);
    // register, training and protection writes, each behind its own latch set
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(8'h42);
    send({8'h42, 56'h0}, 2);
    wait_idle;
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(8'h43);
    send({8'h43, 56'h0}, 2);
    wait_idle;
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(8'h7e);
    send({8'h7e, 56'h0}, 1);
    wait_idle;
    rd_status(8'h00);
    send({`FSW_OP_LATCH_SET, 56'h0}, 1);
    exp_q.push_back(8'h02);
    send({8'h02, 24'h000100, 8'ha5, 24'h0}, 5);
    wait_idle;
    rd_status(8'h00);
    check(8'(exp_q.size()), 8'h00);
    give_verdict;
  end
endmodule
